// *** bench/pdl_duty_ctrl_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module pdl_duty_ctrl_tb;
  // ---------------------------------------------------------------
  // stimulus and observed signals
  // ---------------------------------------------------------------
  logic              clk, rst, reg_we, pwm, sh_o, sh_oe, peer_oe;
  logic [3:0]        reg_addr;
  logic [7:0]        reg_wdata, cur, peer_lvl, rdata, duty, cnt_ff;
  logic signed [7:0] err;
  wire logic         share_line;  // pulled up, low while anyone pulls
  int                fails, checked;

  assign share_line = !((sh_oe && !sh_o) || peer_oe);

  always #2.5 clk = !clk;  // 200 mhz

  // own copy of the period phase, counter goes 0->1 on first edge
  always @(posedge clk or posedge rst) begin
    if (rst) cnt_ff <= 8'h00;
    else cnt_ff <= cnt_ff + 8'h01;
  end

  pdl_duty_ctrl dut (
    .I_CLK(clk), .I_RST(rst), .I_REG_WE(reg_we), .I_REG_ADDR(reg_addr),
    .I_REG_WDATA(reg_wdata), .I_ERR(err), .I_CUR(cur),
    .I_SHARE_IN(share_line), .O_REG_RDATA(rdata), .O_PWM(pwm),
    .O_DUTY(duty), .O_SHARE_O(sh_o), .O_SHARE_OE(sh_oe));

  pdl_share_peer peer (
    .i_clk(clk), .i_rst(rst), .i_level(peer_lvl), .o_pull_oe(peer_oe));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
                       input string what);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: %s seen %0h expected %0h", $time, what,
               seen, exp);
    end
  endtask : check

  // inputs always move 1 ns after the rising edge
  task automatic tick;
    @(posedge clk);
    #1;
  endtask : tick

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_we    = 1'b1;
    tick();
    reg_we = 1'b0;
    tick();  // gap so the strobe is never raised in the same step
  endtask : wr

  // read data is registered: valid one edge after the address
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    reg_addr = a;
    tick();
    d = rdata;
  endtask : rd

  // bounded wait for the edge that brings a given period phase
  task automatic wait_cnt(input logic [7:0] c);
    for (int i = 0; i < 300; i++) begin
      tick();
      if (cnt_ff == c) return;
    end
    fails++;
    $display("Error at %0t: period phase %0h never came", $time, c);
    report_and_stop();
  endtask : wait_cnt

  // three boundaries: shadow load, error sample, filter settle
  task automatic run_case(input logic [7:0] lim, input logic signed [7:0] e,
                          input logic [7:0] exp, input logic [2:0] st);
    int         n;
    logic [7:0] v;
    n = 0;
    wr(pdl_pkg::IDX_DUTY_LIMIT, lim);
    err = e;
    repeat (3) wait_cnt(8'h00);
    check(duty, exp, "duty");
    for (int i = 0; i < 256; i++) begin
      tick();
      if (pwm === 1'b1) n++;
    end
    check(8'(n), exp, "pwm high cycles");
    rd(pdl_pkg::IDX_STATUS, v);
    check({5'h00, v[7:5]}, {5'h00, st}, "mode and trim");
  endtask : run_case

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] v;
    for (int i = 0; i < 12; i++) begin
      rd(4'(i), v);
      check(v, (i == 0) ? pdl_pkg::DUTY_LIMIT_RST : pdl_pkg::COEF_RST,
            "reset value");
    end
    check(duty, 8'h00, "duty after reset");
  endtask : t_reset

  // every coefficient byte is its own register, unmapped place reads 0
  task automatic t_regs;
    logic [7:0] v;
    for (int i = 0; i < 12; i++) begin
      wr(4'(i), 8'(i * 19 + 5));
      rd(4'(i), v);
      check(v, 8'(i * 19 + 5), "readback");
    end
    wr(4'hd, 8'h5a);
    rd(4'hd, v);
    check(v, 8'h00, "unmapped read");
    for (int i = 1; i < 12; i++) wr(4'(i), 8'h00);
    wr(pdl_pkg::IDX_NUM0_HIGH, 8'h01);  // c0 = 1.0, duty follows error
  endtask : t_regs

  // cap at 4n for the boundary codes, high side forced past +16
  // saturation cases stand for a low setpoint only
  task automatic t_limit;
    logic [5:0] codes [4] = '{6'h00, 6'h01, 6'h3a, 6'h3f};
    foreach (codes[k]) begin
      run_case({codes[k], 2'b10}, 8'sd40, {codes[k], 2'b00},
               3'b010);
    end
    run_case({6'h3f, 2'b10}, 8'sd16, 8'd16, 3'b000);
    run_case({6'h3f, 2'b10}, 8'sd17, 8'd252, 3'b010);
  endtask : t_limit

  // with both saturation enables off duty tracks the error, clamped to the limit
  // limit kept above the steady duty except in the clamp case
  task automatic t_linear;
    run_case({6'h02, 2'b00}, 8'sd10, 8'd8, 3'b000);
    run_case({6'h3f, 2'b00}, 8'sd10, 8'd10, 3'b000);
    run_case({6'h3f, 2'b00}, 8'sd40, 8'd40, 3'b000);
  endtask : t_linear

  // low side: forced to zero only when its enable is set
  task automatic t_low;
    run_case({6'h3f, 2'b01}, -8'sd40, 8'd0, 3'b100);
    run_case({6'h3f, 2'b00}, -8'sd40, 8'd0, 3'b000);
    run_case({6'h3f, 2'b11}, 8'sd40, 8'd252, 3'b010);
  endtask : t_low

  // peer carries more current, so this converter trims up by one
  task automatic t_share;
    int n;
    n   = 0;
    cur = 8'h20;
    run_case({6'h3f, 2'b00}, 8'sd10, 8'd11, 3'b001);
    for (int i = 0; i < 256; i++) begin
      tick();
      if (sh_oe === 1'b1) n++;
    end
    check(8'(n), 8'h20, "share pull cycles");
    check({7'h00, sh_o}, 8'h00, "share drives low only");
    cur = 8'h40;
    run_case({6'h3f, 2'b00}, 8'sd10, 8'd10, 3'b000);
  endtask : t_share

  // integrator pole runs duty up to the limit; a second numerator tap
  // doubles a steady error, which c0 = 1.0 alone does not give
  task automatic t_filter;
    wr(pdl_pkg::IDX_DEN1, 8'hc0);  // -1.0 in q2.6, pure integrator
    run_case({6'h05, 2'b00}, 8'sd10, 8'd20, 3'b000);
    wr(pdl_pkg::IDX_DEN1, 8'h00);
    wr(pdl_pkg::IDX_NUM1_HIGH, 8'h01);
    run_case({6'h3f, 2'b00}, 8'sd10, 8'd20, 3'b000);
    wr(pdl_pkg::IDX_NUM1_HIGH, 8'h00);
  endtask : t_filter

  // a mid-period write must not touch the running period
  task automatic t_boundary;
    run_case({6'h3f, 2'b10}, 8'sd40, 8'd252, 3'b010);
    wait_cnt(8'd100);
    wr(pdl_pkg::IDX_DUTY_LIMIT, {6'h0a, 2'b10});
    wait_cnt(8'hff);
    check(duty, 8'd252, "duty before boundary");
    tick();
    check(duty, 8'd40, "duty after boundary");
  endtask : t_boundary

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk       = 1'b0;
    rst       = 1'b1;
    reg_we    = 1'b0;
    reg_addr  = 4'h0;
    reg_wdata = 8'h00;
    err       = 8'sd0;
    cur       = 8'h40;
    peer_lvl  = 8'h40;  // equal levels keep the trim off
    fails     = 0;
    checked   = 0;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_regs();
    t_limit();
    t_linear();
    t_low();
    t_share();
    t_filter();
    t_boundary();
    report_and_stop();
  end
endmodule : pdl_duty_ctrl_tb

`default_nettype wire

// *** bench/pdl_share_peer.sv ***
`timescale 1ns/1ps
`default_nettype none

module pdl_share_peer (
  input  wire logic       i_clk,     // switching clock, shared master
  input  wire logic       i_rst,     // async reset, active high
  input  wire logic [7:0] i_level,   // peer's own current level
  output logic            o_pull_oe  // high while pulling share line low
);
  // ---------------------------------------------------------------
  // period phase and latched level
  // ---------------------------------------------------------------
  logic [7:0] cnt_ff;  // same phase as the converter, both reset together
  logic [7:0] lvl_ff;  // level held for one whole period

  // level latched only at the period end so a pulse is never split
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= 8'h00;
      lvl_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
      if (cnt_ff == 8'hff) begin
        lvl_ff <= i_level;
      end
    end
  end

  // open drain: only ever pulls low, the pull-up gives the high level
  assign o_pull_oe = (cnt_ff < lvl_ff);
endmodule : pdl_share_peer

`default_nettype wire

// *** rtl/pdl_comp_filter.sv ***
`timescale 1ns/1ps
`default_nettype none

module pdl_comp_filter (
  input  wire logic              i_clk,
  input  wire logic              i_rst,
  input  wire logic              i_step,       // one update per period
  input  wire logic signed [7:0] i_err,        // error sample
  input  wire pdl_pkg::pdl_coef_t i_coef,      // active coefficients
  input  wire logic              i_preset,     // load history
  input  wire logic signed [15:0] i_preset_val,
  output logic signed [15:0]     o_y           // duty, 1/256 units
);

  // ---------------------------------------------------------------
  // history
  // ---------------------------------------------------------------
  logic signed [7:0]  e1_ff, e2_ff, e3_ff;     // past errors
  logic signed [15:0] y1_ff, y2_ff, y3_ff;     // past outputs

  // ---------------------------------------------------------------
  // difference equation
  // ---------------------------------------------------------------
  wire logic signed [23:0] pn0 = $signed(i_coef.c0) * i_err;
  wire logic signed [23:0] pn1 = $signed(i_coef.c1) * e1_ff;
  wire logic signed [23:0] pn2 = $signed(i_coef.c2) * e2_ff;
  wire logic signed [23:0] pn3 = $signed(i_coef.c3) * e3_ff;
  wire logic signed [23:0] pd1 = $signed(i_coef.den1) * y1_ff;
  wire logic signed [23:0] pd2 = $signed(i_coef.den2) * y2_ff;
  wire logic signed [23:0] pd3 = $signed(i_coef.den3) * y3_ff;
  // three zeros, three poles: four taps forward, three fed back
  wire logic signed [27:0] num_sum =
    28'(pn0) + 28'(pn1) + 28'(pn2) + 28'(pn3);       // [RULE_09]
  wire logic signed [27:0] den_sum = 28'(pd1) + 28'(pd2) + 28'(pd3);
  // denominator brought to numerator scale before subtraction
  wire logic signed [27:0] acc =
    num_sum - (den_sum <<< (pdl_pkg::NUM_FRAC - pdl_pkg::DEN_FRAC));
  // saturate instead of wrapping so an overflow cannot flip polarity
  wire logic ovf = !((&acc[27:23]) || !(|acc[27:23]));
  wire logic signed [15:0] y_new =
    !ovf ? acc[23:8] : (acc[27] ? 16'sh8000 : 16'sh7fff); // [RULE_08]

  assign o_y = y1_ff;

  // ---------------------------------------------------------------
  // history update; preset avoids windup after a forced period
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      {e1_ff, e2_ff, e3_ff} <= '0;
      {y1_ff, y2_ff, y3_ff} <= '0;
    end else if (i_preset) begin
      {y1_ff, y2_ff, y3_ff} <= {3{i_preset_val}};
    end else if (i_step) begin
      {e1_ff, e2_ff, e3_ff} <= {i_err, e1_ff, e2_ff};
      {y1_ff, y2_ff, y3_ff} <= {y_new, y1_ff, y2_ff};  // [RULE_08]
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  filt_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    !i_step && !i_preset |=> $stable(o_y))                // [RULE_09]
    else $error("filter output moved without a step");
  filt_preset_a: assert property (@(posedge i_clk) disable iff (i_rst)
    i_preset |=> o_y == $past(i_preset_val))              // [RULE_08]
    else $error("filter history not preset");

endmodule : pdl_comp_filter

`default_nettype wire

// *** rtl/pdl_duty_ctrl.sv ***
// Function
// [RULE_01] duty capped at limit code over 64
// [RULE_02] bit one high, bit zero low enable
// [RULE_03] saturation forces zero or limit by polarity
// [RULE_04] inside window duty follows compensation filter
// [RULE_05] outside window duty jumps within one period
// [RULE_06] software sets limit above steady duty
// [RULE_07] software avoids saturation above two volts
// [RULE_08] third order filter, three zeros three poles
// [RULE_09] four numerator, three denominator programmable coefficients
// [RULE_10] numerators as byte pairs, denominators single
// [RULE_11] share line equalises currents of tied converters
// [RULE_12] new settings apply at period boundary
`timescale 1ns/1ps
`default_nettype none

module pdl_duty_ctrl (
  input  wire logic              I_CLK,
  input  wire logic              I_RST,
  input  wire logic              I_REG_WE,     // register write strobe
  input  wire logic [3:0]        I_REG_ADDR,   // register index
  input  wire logic [7:0]        I_REG_WDATA,
  input  wire logic signed [7:0] I_ERR,        // setpoint minus output
  input  wire logic [7:0]        I_CUR,        // own current level
  input  wire logic              I_SHARE_IN,   // share line level
  output logic [7:0]             O_REG_RDATA,
  output logic                   O_PWM,
  output logic [7:0]             O_DUTY,
  output logic                   O_SHARE_O,
  output logic                   O_SHARE_OE
);

  // ---------------------------------------------------------------
  // switching period counter
  // ---------------------------------------------------------------
  logic [7:0] cnt_ff;                          // position in period
  wire logic bnd  = (cnt_ff == pdl_pkg::CNT_LAST); // last clock
  wire logic step = (cnt_ff == pdl_pkg::CNT_STEP); // filter update
  wire logic [7:0] nxt_cnt = bnd ? 8'h00 : cnt_ff + 8'h01;

  // counter free-runs; period is fixed here, set elsewhere in chip
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) cnt_ff <= 8'h00;
    else       cnt_ff <= nxt_cnt;
  end

  // ---------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------
  logic [7:0] reg_ff [pdl_pkg::REG_COUNT];     // written registers

  // writes land in shadow storage at any time
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      for (int i = 0; i < pdl_pkg::REG_COUNT; i++) begin
        reg_ff[i] <= (i == 0) ? pdl_pkg::DUTY_LIMIT_RST
                              : pdl_pkg::COEF_RST;
      end
    end else begin
      for (int i = 0; i < pdl_pkg::REG_COUNT; i++) begin
        if (I_REG_WE && I_REG_ADDR == 4'(i)) reg_ff[i] <= I_REG_WDATA;
      end
    end
  end

  // shadow views of the stored bytes
  wire pdl_pkg::pdl_cfg_t shd_cfg =
    reg_ff[pdl_pkg::IDX_DUTY_LIMIT];             // [RULE_02]
  // high byte first in each numerator pair
  wire pdl_pkg::pdl_coef_t shd_coef = {
    reg_ff[pdl_pkg::IDX_NUM0_HIGH], reg_ff[pdl_pkg::IDX_NUM0_LOW],
    reg_ff[pdl_pkg::IDX_NUM1_HIGH], reg_ff[pdl_pkg::IDX_NUM1_LOW],
    reg_ff[pdl_pkg::IDX_NUM2_HIGH], reg_ff[pdl_pkg::IDX_NUM2_LOW],
    reg_ff[pdl_pkg::IDX_NUM3_HIGH], reg_ff[pdl_pkg::IDX_NUM3_LOW],
    reg_ff[pdl_pkg::IDX_DEN1],      reg_ff[pdl_pkg::IDX_DEN2],
    reg_ff[pdl_pkg::IDX_DEN3]};                  // [RULE_10]

  // ---------------------------------------------------------------
  // active copies, taken only at the period boundary
  // ---------------------------------------------------------------
  pdl_pkg::pdl_cfg_t  act_cfg_ff;              // settings in use
  pdl_pkg::pdl_coef_t act_coef_ff;             // coefficients in use

  // a period never mixes old and new settings
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      act_cfg_ff  <= pdl_pkg::DUTY_LIMIT_RST;
      act_coef_ff <= '0;
    end else if (bnd) begin
      act_cfg_ff  <= shd_cfg;                  // [RULE_12]
      act_coef_ff <= shd_coef;                 // [RULE_12]
    end
  end

  // ---------------------------------------------------------------
  // current share over the wired line
  // ---------------------------------------------------------------
  logic [7:0] cur_ff;                          // level sent this period
  logic [8:0] low_cnt_ff;                      // line-low clocks seen
  logic       trim_ff;                         // below the others
  logic       share_oe_ff;                     // pulling the line low
  wire logic [7:0] nxt_cur = bnd ? I_CUR : cur_ff;
  // line is low as long as the strongest converter pulls it
  wire logic [8:0] meas = low_cnt_ff + {8'h00, !I_SHARE_IN};

  // each converter pulls low for its own level; longest pull wins,
  // so a converter seeing a longer pulse than its own raises duty
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cur_ff      <= 8'h00;
      low_cnt_ff  <= 9'h000;
      trim_ff     <= 1'b0;
      share_oe_ff <= 1'b0;
    end else begin
      cur_ff      <= nxt_cur;
      low_cnt_ff  <= bnd ? 9'h000 : meas;
      if (bnd) trim_ff <= ({1'b0, cur_ff} < meas); // [RULE_11]
      share_oe_ff <= (nxt_cnt < nxt_cur);          // [RULE_11]
    end
  end

  // ---------------------------------------------------------------
  // compensation filter
  // ---------------------------------------------------------------
  logic signed [7:0]  err_ff;                  // sample for this period
  logic               preset;                  // after forced period
  wire logic signed [15:0] filt_y;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST)     err_ff <= 8'sh00;
    else if (step) err_ff <= I_ERR;
  end

  pdl_comp_filter u_filter (
    .i_clk        (I_CLK),
    .i_rst        (I_RST),
    .i_step       (step),
    .i_err        (I_ERR),
    .i_coef       (act_coef_ff),
    .i_preset     (preset),
    .i_preset_val ($signed({8'h00, O_DUTY})),
    .o_y          (filt_y)
  );

  // ---------------------------------------------------------------
  // duty selection at the boundary
  // ---------------------------------------------------------------
  pdl_pkg::pdl_mode_t mode_ff;                 // mode of this period
  logic [7:0]         duty_ff;                 // duty in 1/256 units
  logic               pwm_ff;

  // window comparators on the error sample
  wire logic above = (err_ff > pdl_pkg::WIN_HALF);
  wire logic below = (err_ff < -pdl_pkg::WIN_HALF);
  // n/64 of the period is n*4 of 256 clocks
  wire logic [7:0] lim_duty = {shd_cfg.limit_code, 2'b00}; // [RULE_01]
  wire logic signed [16:0] y_trim =
    $signed({filt_y[15], filt_y}) + $signed({16'h0000, trim_ff});
  wire logic lin_over = !y_trim[16] && (y_trim[15:0] > {8'h00, lim_duty});
  // filter path plus trim, clamped to zero and the limit
  wire logic [7:0] lin_duty = y_trim[16] ? 8'h00 :
                              lin_over   ? lim_duty :
                                           y_trim[7:0];      // [RULE_04]
  // polarity picks the bound; each side needs its own enable
  wire pdl_pkg::pdl_mode_t nxt_mode =
    (shd_cfg.hi_en && above) ? pdl_pkg::MODE_SAT_HI :
    (shd_cfg.lo_en && below) ? pdl_pkg::MODE_SAT_LO :
                               pdl_pkg::MODE_LINEAR;         // [RULE_03]
  logic [7:0] nxt_duty;

  always_comb begin
    nxt_duty = duty_ff;
    if (bnd) begin
      unique case (nxt_mode)
        pdl_pkg::MODE_SAT_HI: nxt_duty = lim_duty;          // [RULE_05]
        pdl_pkg::MODE_SAT_LO: nxt_duty = 8'h00;             // [RULE_05]
        pdl_pkg::MODE_LINEAR: nxt_duty = lin_duty;
      endcase
    end
  end

  // forced periods reload filter history with the applied duty
  assign preset = step && (mode_ff != pdl_pkg::MODE_LINEAR) &&
                  (cnt_ff != 8'h00);

  // duty and output level for the next clock
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      mode_ff <= pdl_pkg::MODE_LINEAR;
      duty_ff <= 8'h00;
      pwm_ff  <= 1'b0;
    end else begin
      if (bnd) mode_ff <= nxt_mode;
      duty_ff <= nxt_duty;
      pwm_ff  <= (nxt_cnt < nxt_duty);         // [RULE_01]
    end
  end

  // ---------------------------------------------------------------
  // read path, one clock latency, unmapped reads zero
  // ---------------------------------------------------------------
  wire logic [7:0] status = {mode_ff, trim_ff, 5'h00};
  wire logic [7:0] rd_mux =
    (I_REG_ADDR < 4'(pdl_pkg::REG_COUNT)) ? reg_ff[I_REG_ADDR] :
    (I_REG_ADDR == pdl_pkg::IDX_STATUS)  ? status : 8'h00;
  logic [7:0] rdata_ff;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) rdata_ff <= 8'h00;
    else       rdata_ff <= rd_mux;
  end

  assign O_REG_RDATA = rdata_ff;
  assign O_PWM       = pwm_ff;
  assign O_DUTY      = duty_ff;
  assign O_SHARE_O   = 1'b0 & pwm_ff;          // open drain, low only
  assign O_SHARE_OE  = share_oe_ff;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  sequence s_hi_trig;
    step ##1 (bnd && shd_cfg.hi_en && above);
  endsequence
  sequence s_lo_trig;
    step ##1 (bnd && shd_cfg.lo_en && !shd_cfg.hi_en && below);
  endsequence

  duty_cap_a: assert property (
    duty_ff <= {act_cfg_ff.limit_code, 2'b00})   // [RULE_01]
    else $error("duty above programmed limit");
  pwm_shape_a: assert property (
    pwm_ff == (cnt_ff < duty_ff))                // [RULE_01]
    else $error("pwm level does not match duty");
  sat_hi_a: assert property (
    s_hi_trig |=> duty_ff == $past(lim_duty) &&
                  mode_ff == pdl_pkg::MODE_SAT_HI) // [RULE_05]
    else $error("high saturation did not reach limit");
  sat_lo_a: assert property (
    s_lo_trig |=> duty_ff == 8'h00 ##1 pwm_ff == 1'b0) // [RULE_03]
    else $error("low saturation did not reach zero");
  window_lin_a: assert property (
    bnd && !above && !below |=> mode_ff == pdl_pkg::MODE_LINEAR &&
                                duty_ff == $past(lin_duty)) // [RULE_04]
    else $error("in-window period not linear");
  cfg_hold_a: assert property (
    !bnd |=> $stable(act_cfg_ff) && $stable(act_coef_ff)) // [RULE_12]
    else $error("active settings changed mid period");
  cfg_take_a: assert property (
    bnd |=> act_cfg_ff == $past(shd_cfg))        // [RULE_12]
    else $error("settings not taken at boundary");
  share_pulse_a: assert property (
    share_oe_ff == (cnt_ff < cur_ff))            // [RULE_11]
    else $error("share pulse width wrong");
  pair_read_a: assert property (
    I_REG_ADDR == pdl_pkg::IDX_NUM0_LOW |=>
      O_REG_RDATA == $past(shd_coef.c0[7:0]))    // [RULE_10]
    else $error("coefficient low byte readback wrong");

endmodule : pdl_duty_ctrl

`default_nettype wire

// *** shared/pdl_pkg.sv ***
package pdl_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS = 5000;  // 200 mhz clock
  localparam int unsigned SW_PERIOD_NS  = 1280;  // switching period
  localparam int unsigned SW_CYCLES     =
    (SW_PERIOD_NS * 1000) / CLK_PERIOD_PS;       // 256 clocks
  localparam logic [7:0]  CNT_LAST      = 8'(SW_CYCLES - 1);
  localparam logic [7:0]  CNT_STEP      = 8'(SW_CYCLES - 2);

  // ---------------------------------------------------------------
  // register indices on the register port
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_DUTY_LIMIT = 4'h0;  // duty_cycle_limit_ctrl
  localparam logic [3:0] IDX_NUM0_HIGH  = 4'h1;  // numerator_coef0_high
  localparam logic [3:0] IDX_NUM0_LOW   = 4'h2;
  localparam logic [3:0] IDX_NUM1_HIGH  = 4'h3;
  localparam logic [3:0] IDX_NUM1_LOW   = 4'h4;
  localparam logic [3:0] IDX_NUM2_HIGH  = 4'h5;
  localparam logic [3:0] IDX_NUM2_LOW   = 4'h6;
  localparam logic [3:0] IDX_NUM3_HIGH  = 4'h7;
  localparam logic [3:0] IDX_NUM3_LOW   = 4'h8;
  localparam logic [3:0] IDX_DEN1       = 4'h9;  // denominator_coef1
  localparam logic [3:0] IDX_DEN2       = 4'ha;
  localparam logic [3:0] IDX_DEN3       = 4'hb;
  localparam logic [3:0] IDX_STATUS     = 4'hc;  // read-only state
  localparam int unsigned REG_COUNT     = 12;    // writable registers

  // ---------------------------------------------------------------
  // fields and reset values
  // ---------------------------------------------------------------
  localparam int unsigned LIMIT_MSB      = 7;
  localparam int unsigned LIMIT_LSB      = 2;
  localparam int unsigned HI_BIT         = 1;
  localparam int unsigned LO_BIT         = 0;
  localparam logic [7:0]  DUTY_LIMIT_RST = 8'he8;
  localparam logic [7:0]  COEF_RST       = 8'h00;

  // ---------------------------------------------------------------
  // loop arithmetic
  // ---------------------------------------------------------------
  localparam logic signed [7:0] WIN_HALF = 8'sh10; // window half width
  localparam int unsigned NUM_FRAC = 8;            // numerator q8.8
  localparam int unsigned DEN_FRAC = 6;            // denominator q2.6

  typedef struct packed {
    logic [5:0] limit_code;  // duty_limit_code, n/64
    logic       hi_en;       // high_saturation_enable
    logic       lo_en;       // low_saturation_enable
  } pdl_cfg_t;

  typedef struct packed {
    logic [15:0] c0;
    logic [15:0] c1;
    logic [15:0] c2;
    logic [15:0] c3;
    logic [7:0]  den1;
    logic [7:0]  den2;
    logic [7:0]  den3;
  } pdl_coef_t;

  typedef enum logic [1:0] {
    MODE_LINEAR = 2'b00,
    MODE_SAT_HI = 2'b01,
    MODE_SAT_LO = 2'b10
  } pdl_mode_t;

endpackage : pdl_pkg
